// file: rtl/pm_cfg_consts.vh
/*
 Constants for the power management function configuration header:
 register offsets, field positions, reset values and fixed read values.
 Assumes inclusion by bare name from rtl/pm_function_config_header.v.
*/
`ifndef PM_CFG_CONSTS_VH
`define PM_CFG_CONSTS_VH

`define OFF_MAKER_ID     8'h00
`define OFF_PART_ID      8'h02
`define OFF_COMMAND      8'h04
`define OFF_STATUS       8'h06
`define OFF_REVISION     8'h08
`define OFF_PROG_IF      8'h09
`define OFF_SUB_CLASS    8'h0a
`define OFF_BASE_CLASS   8'h0b
`define OFF_LATENCY      8'h0d
`define OFF_HEADER_TYPE  8'h0e
`define OFF_IO_BASE      8'h20
`define OFF_PIN_SELECT   8'h40
`define OFF_GEN_SETUP    8'h41
`define OFF_PROG_IF_OVR  8'h61
`define OFF_SUB_OVR      8'h62
`define OFF_BASE_OVR     8'h63
`define OFF_MAKER_ID_HI  8'h01
`define OFF_PART_ID_HI   8'h03
`define OFF_COMMAND_HI   8'h05
`define OFF_STATUS_HI    8'h07
`define OFF_IO_BASE_HI   8'h21
`define OFF_IO_BASE_B2   8'h22
`define OFF_IO_BASE_B3   8'h23

`define RST_PROG_IF      8'h00
`define RST_SUB_CLASS    8'h00
`define RST_BASE_CLASS   8'h0c
`define RST_LATENCY      8'h16
`define RST_IO_BASE_HI   8'h00
`define RST_PIN_SELECT   8'hc0
`define RST_GEN_SETUP    8'h00
`define RST_IO_SPACE     1'b0
`define RST_RDATA        8'h00
`define VAL_ZERO         8'h00

`define VAL_HEADER_TYPE  8'h00
`define VAL_IO_BASE_LO   8'h01
`define VAL_STATUS_LO    8'h80
`define VAL_STATUS_HI    8'h02
`define MASK_PIN_SELECT  8'hc0
`define MASK_GEN_SETUP   8'hce
`define CMD_IO_SPACE_BIT 0

`define PIN_LINE_FOUR    7
`define PIN_LINE_THREE   6
`define GEN_DEBOUNCE     7
`define GEN_TMR_RESET    6
`define GEN_TMR_WIDTH    3
`define GEN_FRAME_RESUME 2
`define GEN_THROTTLE     1

`endif

// file: rtl/pm_function_config_header.v
/*
 Configuration header and power management setup bytes of the power
 management function, reached over byte-wide configuration accesses.
 Assumes a host bridge front end that presents one byte per access as a
 single-cycle strobe on i_clk, and an I/O cycle decoder that supplies the
 I/O address bits 15..8 from logic on the same clock.
*/
`timescale 1ns/1ps
`include "pm_cfg_consts.vh"

module pm_function_config_header #(
  parameter [15:0] MAKER_ID = 16'h1234, // Arbitrary value
  parameter [15:0] PART_ID  = 16'h5678, // Arbitrary value
  parameter [7:0]  REVISION = 8'h00     // Arbitrary value
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_cfg_rd,
  input  wire       i_cfg_wr,
  input  wire [7:0] i_cfg_addr,
  input  wire [7:0] i_cfg_wdata,
  output reg  [7:0] o_cfg_rdata,
  input  wire [7:0] i_io_addr_hi,
  input  wire       i_io_access,
  output wire       o_pm_io_select,
  output wire       o_io_space_enable,
  output wire       o_general_pin_line_four,
  output wire       o_general_pin_line_three,
  output wire       o_button_debounce_enable,
  output wire       o_pm_timer_reset_enable,
  output wire       o_pm_timer_width_select,
  output wire       o_frame_activity_resume_enable,
  output wire       o_throttle_timebase_select
);

  reg       io_space_enable;
  reg [7:0] prog_if;
  reg [7:0] sub_class;
  reg [7:0] base_class;
  reg [7:0] latency;
  reg [7:0] io_base_hi;
  reg [7:0] pin_select;
  reg [7:0] gen_setup;
  reg       next_io_space_enable;
  reg [7:0] next_prog_if;
  reg [7:0] next_sub_class;
  reg [7:0] next_base_class;
  reg [7:0] next_latency;
  reg [7:0] next_io_base_hi;
  reg [7:0] next_pin_select;
  reg [7:0] next_gen_setup;
  reg [7:0] next_rdata;
  reg [7:0] next_cfg_rdata;
  wire      wr_command;
  wire      wr_prog_if;
  wire      wr_sub_class;
  wire      wr_base_class;
  wire      wr_latency;
  wire      wr_io_base;
  wire      wr_pin_select;
  wire      wr_gen_setup;
  wire      base_match;

  // One strobe at one byte offset; every writable byte decodes through this
  function hits;
    input       strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hits = strobe & (addr == offset);
    end
  endfunction

  // Reserved bits never latch, so they read back zero whatever was written
  function [7:0] keep_bits;
    input [7:0] data;
    input [7:0] mask;
    begin
      keep_bits = data & mask;
    end
  endfunction

  // Writes to read-only bytes decode to nothing and are dropped
  assign wr_command    = hits(i_cfg_wr, i_cfg_addr, `OFF_COMMAND);
  assign wr_prog_if    = hits(i_cfg_wr, i_cfg_addr, `OFF_PROG_IF_OVR);
  assign wr_sub_class  = hits(i_cfg_wr, i_cfg_addr, `OFF_SUB_OVR);
  assign wr_base_class = hits(i_cfg_wr, i_cfg_addr, `OFF_BASE_OVR);
  assign wr_latency    = hits(i_cfg_wr, i_cfg_addr, `OFF_LATENCY);
  assign wr_io_base    = hits(i_cfg_wr, i_cfg_addr, `OFF_IO_BASE_HI);
  assign wr_pin_select = hits(i_cfg_wr, i_cfg_addr, `OFF_PIN_SELECT);
  assign wr_gen_setup  = hits(i_cfg_wr, i_cfg_addr, `OFF_GEN_SETUP);

  // Every register loads its next value on each clock; holding is a choice
  // of next value, so no enable sits in the clock path
  always @* begin
    next_io_space_enable = io_space_enable;
    if (wr_command) begin
      next_io_space_enable = i_cfg_wdata[`CMD_IO_SPACE_BIT];
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_space_enable <= `RST_IO_SPACE;
    end else begin
      io_space_enable <= next_io_space_enable;
    end
  end

  // Overrides are write-only; their value shows only through the class bytes
  always @* begin
    next_prog_if = prog_if;
    if (wr_prog_if) begin
      next_prog_if = i_cfg_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_if <= `RST_PROG_IF;
    end else begin
      prog_if <= next_prog_if;
    end
  end

  always @* begin
    next_sub_class = sub_class;
    if (wr_sub_class) begin
      next_sub_class = i_cfg_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sub_class <= `RST_SUB_CLASS;
    end else begin
      sub_class <= next_sub_class;
    end
  end

  always @* begin
    next_base_class = base_class;
    if (wr_base_class) begin
      next_base_class = i_cfg_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_class <= `RST_BASE_CLASS;
    end else begin
      base_class <= next_base_class;
    end
  end

  always @* begin
    next_latency = latency;
    if (wr_latency) begin
      next_latency = i_cfg_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latency <= `RST_LATENCY;
    end else begin
      latency <= next_latency;
    end
  end

  // Only the high byte of the base is live; the block is 256-byte aligned
  always @* begin
    next_io_base_hi = io_base_hi;
    if (wr_io_base) begin
      next_io_base_hi = i_cfg_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_base_hi <= `RST_IO_BASE_HI;
    end else begin
      io_base_hi <= next_io_base_hi;
    end
  end

  always @* begin
    next_pin_select = pin_select;
    if (wr_pin_select) begin
      next_pin_select = keep_bits(i_cfg_wdata, `MASK_PIN_SELECT);
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_select <= `RST_PIN_SELECT;
    end else begin
      pin_select <= next_pin_select;
    end
  end

  always @* begin
    next_gen_setup = gen_setup;
    if (wr_gen_setup) begin
      next_gen_setup = keep_bits(i_cfg_wdata, `MASK_GEN_SETUP);
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gen_setup <= `RST_GEN_SETUP;
    end else begin
      gen_setup <= next_gen_setup;
    end
  end

  // Read mux; unmapped bytes and write-only overrides read zero
  always @* begin
    next_rdata = `VAL_ZERO;
    case (i_cfg_addr)
      `OFF_MAKER_ID: begin
        next_rdata = MAKER_ID[7:0];
      end
      `OFF_MAKER_ID_HI: begin
        next_rdata = MAKER_ID[15:8];
      end
      `OFF_PART_ID: begin
        next_rdata = PART_ID[7:0];
      end
      `OFF_PART_ID_HI: begin
        next_rdata = PART_ID[15:8];
      end
      `OFF_COMMAND: begin
        next_rdata = {7'h00, io_space_enable};
      end
      `OFF_COMMAND_HI: begin
        next_rdata = `VAL_ZERO;
      end
      `OFF_STATUS: begin
        next_rdata = `VAL_STATUS_LO;
      end
      `OFF_STATUS_HI: begin
        next_rdata = `VAL_STATUS_HI;
      end
      `OFF_REVISION: begin
        next_rdata = REVISION;
      end
      `OFF_PROG_IF: begin
        next_rdata = prog_if;
      end
      `OFF_SUB_CLASS: begin
        next_rdata = sub_class;
      end
      `OFF_BASE_CLASS: begin
        next_rdata = base_class;
      end
      `OFF_LATENCY: begin
        next_rdata = latency;
      end
      `OFF_HEADER_TYPE: begin
        next_rdata = `VAL_HEADER_TYPE;
      end
      `OFF_IO_BASE: begin
        next_rdata = `VAL_IO_BASE_LO;
      end
      `OFF_IO_BASE_HI: begin
        next_rdata = io_base_hi;
      end
      `OFF_IO_BASE_B2: begin
        next_rdata = `VAL_ZERO;
      end
      `OFF_IO_BASE_B3: begin
        next_rdata = `VAL_ZERO;
      end
      `OFF_PIN_SELECT: begin
        next_rdata = pin_select;
      end
      `OFF_GEN_SETUP: begin
        next_rdata = gen_setup;
      end
      default: begin
        next_rdata = `VAL_ZERO;
      end
    endcase
  end

  // Read data is registered so it stands from one cycle after the strobe
  // until the next read; a write never disturbs it
  always @* begin
    next_cfg_rdata = o_cfg_rdata;
    if (i_cfg_rd) begin
      next_cfg_rdata = next_rdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= `RST_RDATA;
    end else begin
      o_cfg_rdata <= next_cfg_rdata;
    end
  end

  // Decode is blocked while the I/O space bit is clear
  assign base_match        = (i_io_addr_hi == io_base_hi);
  assign o_pm_io_select    = i_io_access & io_space_enable & base_match;
  assign o_io_space_enable = io_space_enable;

  assign o_general_pin_line_four        = pin_select[`PIN_LINE_FOUR];
  assign o_general_pin_line_three       = pin_select[`PIN_LINE_THREE];
  assign o_button_debounce_enable       = gen_setup[`GEN_DEBOUNCE];
  assign o_pm_timer_reset_enable        = gen_setup[`GEN_TMR_RESET];
  assign o_pm_timer_width_select        = gen_setup[`GEN_TMR_WIDTH];
  assign o_frame_activity_resume_enable = gen_setup[`GEN_FRAME_RESUME];
  assign o_throttle_timebase_select     = gen_setup[`GEN_THROTTLE];

endmodule

// file: tb/pm_cfg_host.sv
/* Host bridge model issuing byte-wide configuration cycles.
 Assumes strobes are taken on the rising edge of i_clk. */
`timescale 1ns/1ps
module pm_cfg_host (
  input  wire       i_clk,
  output reg        o_rd,
  output reg        o_wr,
  output reg  [7:0] o_addr,
  output reg  [7:0] o_wdata
);
  initial {o_rd, o_wr, o_addr, o_wdata} = 18'h0;
  // Idle bus shows inverted values so stale data never looks valid
  task acc(input logic w, input logic [7:0] a, d);
    @(negedge i_clk) {o_rd, o_wr, o_addr, o_wdata} = {!w, w, a, d};
    @(negedge i_clk) {o_rd, o_wr, o_addr, o_wdata} = {2'b00, ~a, ~d};
    @(negedge i_clk);
  endtask
endmodule

// file: tb/pm_cfg_header_props_props.sv
/* Checker for the configuration header ports.
 Assumes a bind from the bench top and one access per strobe. */
`timescale 1ns/1ps
module pm_cfg_header_props (
  input logic       i_clk,
  input logic       i_rst_n,
  input logic       i_cfg_rd,
  input logic       i_cfg_wr,
  input logic [7:0] i_cfg_addr,
  input logic [7:0] i_cfg_wdata,
  input logic [7:0] o_cfg_rdata,
  input logic       o_pm_io_select,
  input logic       o_io_space_enable,
  input logic       o_general_pin_line_four,
  input logic       o_pm_timer_width_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  io_gate_a: assert property (!o_io_space_enable |-> !o_pm_io_select) else $error("io select");
  cmd_write_a: assert property (i_cfg_wr && i_cfg_addr == 8'h04 |=> o_io_space_enable == $past(i_cfg_wdata[0]))
    else $error("cmd write");
  cmd_read_a: assert property (i_cfg_rd && i_cfg_addr == 8'h04 |=> o_cfg_rdata[7:1] == 7'h00) else $error("cmd");
  stat_low_a: assert property (i_cfg_rd && i_cfg_addr == 8'h06 |=> o_cfg_rdata == 8'h80) else $error("stat");
  stat_high_a: assert property (i_cfg_rd && i_cfg_addr == 8'h07 |=> o_cfg_rdata == 8'h02) else $error("stat");
  hdr_type_a: assert property (i_cfg_rd && i_cfg_addr == 8'h0e |=> o_cfg_rdata == 8'h00) else $error("hdr");
  base_fixed_a: assert property (i_cfg_rd && i_cfg_addr == 8'h20 |=> o_cfg_rdata == 8'h01) else $error("base");
  pin_four_a: assert property (i_cfg_wr && i_cfg_addr == 8'h40 |=> o_general_pin_line_four == $past(i_cfg_wdata[7]))
    else $error("pin");
  tmr_width_a: assert property (i_cfg_wr && i_cfg_addr == 8'h41 |=> o_pm_timer_width_select == $past(i_cfg_wdata[3]))
    else $error("width");
endmodule

// file: tb/pm_function_config_header_tb.sv
/* Bench: reset reads, write-then-read table, I/O decode.
 Assumes the host model and checker compile first. */
`timescale 1ns/1ps
module pm_function_config_header_tb;
  logic       clk = 0, rst_n = 0, rd, wr, io_acc = 0, sel, en, p4, p3;
  logic [7:0] addr, wdata, rdata, io_hi = 8'h00;
  logic [4:0] setup;
  int         err_count = 0, samples_checked = 0;
  logic [15:0] rtab [18] = '{16'h0034, 16'h0112, 16'h0278, 16'h0356, 16'h0400, 16'h0500, 16'h0680, 16'h0702,
    16'h0900, 16'h0b0c, 16'h0d16, 16'h0e00, 16'h2001, 16'h2100, 16'h2200, 16'h2300, 16'h40c0, 16'h4100};
  logic [31:0] wtab [13] = '{32'h04ff0401, 32'h06ff0680, 32'h00ff0034, 32'h0eff0e00, 32'h0da50da5, 32'h615a095a,
    32'h623c0a3c, 32'h63e10be1, 32'h219b219b, 32'h20ff2001, 32'h23ff2300, 32'h40004000, 32'h41ff41ce};
  always #5 clk = ~clk;
  pm_cfg_host u_pm_cfg_host (.i_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  pm_function_config_header u_pm_function_config_header (.i_clk(clk), .i_rst_n(rst_n), .i_cfg_rd(rd),
    .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_io_addr_hi(io_hi),
    .i_io_access(io_acc), .o_pm_io_select(sel), .o_io_space_enable(en), .o_general_pin_line_four(p4),
    .o_general_pin_line_three(p3), .o_button_debounce_enable(setup[4]), .o_pm_timer_reset_enable(setup[3]),
    .o_pm_timer_width_select(setup[2]), .o_frame_activity_resume_enable(setup[1]),
    .o_throttle_timebase_select(setup[0]));
  task check(input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    check({p4, p3, en, setup}, 8'hc0);
    foreach (rtab[i]) begin
      u_pm_cfg_host.acc(0, rtab[i][15:8], 8'h00);
      check(rdata, rtab[i][7:0]);
    end
    $display("reset reads done");
    foreach (wtab[i]) begin
      u_pm_cfg_host.acc(1, wtab[i][31:24], wtab[i][23:16]);
      u_pm_cfg_host.acc(0, wtab[i][15:8], 8'h00);
      check(rdata, wtab[i][7:0]);
    end
    check({p4, p3, en, setup}, 8'h3f);
    $display("write reads done");
    // Base byte 9b and decode enabled from the table above
    io_hi = 8'h9b;
    io_acc = 1;
    #1 check({7'h00, sel}, 8'h01);
    @(negedge clk) io_hi = 8'h9a;
    #1 check({7'h00, sel}, 8'h00);
    io_hi = 8'h9b;
    u_pm_cfg_host.acc(1, 8'h04, 8'h00);
    check({7'h00, sel}, 8'h00);
    $display("io decode done");
    give_verdict;
  end
endmodule
bind pm_function_config_header pm_cfg_header_props u_pm_cfg_header_props (.i_clk, .i_rst_n, .i_cfg_rd, .i_cfg_wr,
  .i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata, .o_pm_io_select, .o_io_space_enable, .o_general_pin_line_four,
  .o_pm_timer_width_select);
